/* File: src/arsm_top.sv */
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE_01 - Start allowed only when enabled, breaker assigned, no external block.
// RULE_02 - Standby when breaker open, no initiation, no blocking.
// RULE_03 - No reclose shot is ever issued from Standby.
// RULE_04 - Breaker closing in Standby starts hold timer, enters hold.
// RULE_05 - Hold goes to Ready only on timer expiry with breaker closed.
// RULE_06 - Ready when closed, hold expired, no initiation, no blocking.
// RULE_07 - Reclose start accepted only from Ready.
// RULE_08 - Run entered from Ready, breaker closed, unblocked, initiation asserted.
// RULE_09 - Blocked while a blocking function is asserted, leave when gone.
// RULE_10 - Listed failure conditions force Lockout.
// RULE_11 - Lockout left after reset input and lockout reset timer expiry.
// RULE_12 - Service alarms never cause Lockout.
// RULE_13 - Fault timer runs; trip before expiry moves to await-open.
// RULE_14 - Breaker must open within 200 ms, then dead timer starts.
// RULE_15 - Dead timer runs to end unless block or lockout.
// RULE_16 - Reclose only if open, ready, no pickup, trips or general trip.
// RULE_17 - Shot counter increments before the reclose command.
// RULE_18 - Confirmation timer starts before entering Reclosing.
// RULE_19 - Breaker closing during confirmation starts settle timer.
// RULE_20 - Settle expiry without fault returns Ready, sets successful.
// RULE_21 - Fault in settling reruns shot; shots exhausted give Lockout, failed.
// RULE_22 - Trip during hold keeps timer; expiry with breaker open gives Standby.
// RULE_23 - Timers count clock ticks; reset gives Standby, shot counter zero.
module arsm_top
  import arsm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_brk_closed,
  input wire logic i_brk_ready,
  input wire logic i_init_pickup,
  input wire logic i_init_trip,
  input wire logic i_gen_trip,
  input wire logic i_block_fc,
  input wire logic [1:0] i_external_block_inputs,
  input wire logic i_lo_reset,
  input wire logic i_rate_exceeded,
  input wire logic i_svc_alarm,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_reclose_cmd,
  output logic [3:0] o_shot_count,
  output logic o_successful,
  output logic o_failed,
  output logic [2:0] o_state
);

  // Whole module state in one struct.
  typedef struct packed {
    arsm_top_e top;
    arsm_sub_e sub;
    logic [31:0] timer;
    logic [3:0] shot;
    logic prev_closed;
    logic lo_req;
    logic reclose;
    logic ok;
    logic fail;
    logic [31:0] rdata;
    arsm_cfg_s cfg;
  } arsm_state_s;

  arsm_state_s st;
  arsm_state_s next_st;
  arsm_in_s in;

  // Gather the pins into one bundle.
  assign in = '{i_brk_closed, i_brk_ready, i_init_pickup, i_init_trip, i_gen_trip,
                i_block_fc, i_external_block_inputs, i_lo_reset, i_rate_exceeded,
                i_svc_alarm};

  logic allowed;
  logic blocked;
  logic timer_done;
  logic init_any;
  logic close_edge;

  // Function availability and blocking summary.
  always_comb begin
    allowed = st.cfg.ctrl[CTRL_EN] && st.cfg.ctrl[CTRL_BRK]
              && (in.ext_block == 2'h0); // RULE_01
    blocked = in.block_fc || (in.ext_block != 2'h0);
    timer_done = (st.timer == 32'h0000_0000);
    init_any = in.init_pickup || in.init_trip;
    close_edge = in.brk_closed && !st.prev_closed;
  end

  // Next-state logic for the registers and both state machines.
  always_comb begin
    next_st = st;
    next_st.prev_closed = in.brk_closed;
    next_st.reclose = 1'b0;
    next_st.rdata = 32'h0000_0000;
    if (!timer_done) begin
      next_st.timer = st.timer - 32'h0000_0001; // RULE_23
    end
    // Register writes and reads.
    if (i_wr) begin
      case (i_addr)
        REG_CTRL: next_st.cfg.ctrl = i_wdata[2:0];
        REG_SHOTS: next_st.cfg.shots = i_wdata[3:0];
        REG_T_HOLD: next_st.cfg.t_hold = i_wdata;
        REG_T_FAULT: next_st.cfg.t_fault = i_wdata;
        REG_T_DEAD: next_st.cfg.t_dead = i_wdata;
        REG_T_CONF: next_st.cfg.t_conf = i_wdata;
        REG_T_SETTLE: next_st.cfg.t_settle = i_wdata;
        REG_T_LORST: next_st.cfg.t_lorst = i_wdata;
        default: next_st.cfg = st.cfg;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        REG_CTRL: next_st.rdata = {29'h0, st.cfg.ctrl};
        REG_SHOTS: next_st.rdata = {28'h0, st.cfg.shots};
        REG_T_HOLD: next_st.rdata = st.cfg.t_hold;
        REG_T_FAULT: next_st.rdata = st.cfg.t_fault;
        REG_T_DEAD: next_st.rdata = st.cfg.t_dead;
        REG_T_CONF: next_st.rdata = st.cfg.t_conf;
        REG_T_SETTLE: next_st.rdata = st.cfg.t_settle;
        REG_T_LORST: next_st.rdata = st.cfg.t_lorst;
        REG_STATUS: next_st.rdata = {18'h0, st.fail, st.ok, st.shot, 1'b0, st.sub,
                                     1'b0, st.top};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    // Service alarms are deliberately not read here, so they can never lock out. // RULE_12
    case (st.top)
      ARSM_STANDBY: begin
        // No shot is possible here; only a closing or a block while enabled moves us on.
        if (blocked && st.cfg.ctrl[CTRL_EN]) begin
          next_st.top = ARSM_BLOCKED; // RULE_09
        end else if (close_edge) begin
          next_st.top = ARSM_HOLD; // RULE_04
          next_st.timer = st.cfg.t_hold;
        end
      end
      ARSM_HOLD: begin
        // Timer keeps running even if a trip opens the breaker.
        if (timer_done) begin
          next_st.top = in.brk_closed ? ARSM_READY : ARSM_STANDBY; // RULE_05 RULE_22
        end
      end
      ARSM_READY: begin
        if (!in.brk_closed) begin
          next_st.top = ARSM_STANDBY; // RULE_02
        end else if (blocked && st.cfg.ctrl[CTRL_EN]) begin
          next_st.top = ARSM_BLOCKED; // RULE_09
        end else if (allowed && init_any && st.prev_closed) begin
          next_st.top = ARSM_RUN; // RULE_07 RULE_08
          next_st.sub = ARSM_FAULT;
          next_st.timer = st.cfg.t_fault;
          next_st.shot = 4'h0;
          next_st.ok = 1'b0;
          next_st.fail = 1'b0;
        end
      end
      ARSM_BLOCKED: begin
        if (!blocked) begin
          next_st.top = in.brk_closed ? ARSM_READY : ARSM_STANDBY; // RULE_09 RULE_06
        end
      end
      ARSM_LOCKOUT: begin
        // The reset request is held until its timer runs out.
        if (in.lo_reset && !st.lo_req) begin
          next_st.lo_req = 1'b1;
          next_st.timer = st.cfg.t_lorst;
        end else if (st.lo_req && timer_done) begin
          next_st.lo_req = 1'b0; // RULE_11
          next_st.top = in.brk_closed ? ARSM_READY : ARSM_STANDBY;
        end
      end
      ARSM_RUN: begin
        if (blocked) begin
          next_st.top = ARSM_BLOCKED; // RULE_09
        end else if (in.rate_exceeded) begin
          next_st.top = ARSM_LOCKOUT; // RULE_10
        end else begin
          case (st.sub)
            ARSM_FAULT: begin
              if (in.init_trip) begin
                next_st.sub = ARSM_WAIT_OPEN; // RULE_13
                next_st.timer = 32'(BRK_SUPV_CYC);
              end else if (timer_done) begin
                next_st.top = ARSM_LOCKOUT; // RULE_10
              end
            end
            ARSM_WAIT_OPEN: begin
              if (!in.brk_closed) begin
                next_st.sub = ARSM_DEAD; // RULE_14
                next_st.timer = st.cfg.t_dead;
              end else if (timer_done) begin
                next_st.top = ARSM_LOCKOUT; // RULE_10
              end
            end
            ARSM_DEAD: begin
              // A close during dead time can only be a manual close.
              if (in.brk_closed) begin
                next_st.top = ARSM_LOCKOUT; // RULE_10
              end else if (timer_done) begin // RULE_15
                if (in.init_pickup || in.init_trip || in.gen_trip
                    || (st.cfg.ctrl[CTRL_RDY_USED] && !in.brk_ready)) begin
                  next_st.top = ARSM_LOCKOUT; // RULE_10 RULE_16
                end else begin
                  next_st.shot = st.shot + 4'h1; // RULE_17
                  next_st.reclose = 1'b1; // RULE_16
                  next_st.timer = st.cfg.t_conf; // RULE_18
                  next_st.sub = ARSM_RECLOSING;
                end
              end
            end
            ARSM_RECLOSING: begin
              if (in.brk_closed) begin
                next_st.sub = ARSM_SETTLE; // RULE_19
                next_st.timer = st.cfg.t_settle;
              end else if (timer_done) begin
                next_st.top = ARSM_LOCKOUT; // RULE_10
              end
            end
            ARSM_SETTLE: begin
              if (init_any) begin
                if (st.shot >= st.cfg.shots) begin
                  next_st.top = ARSM_LOCKOUT; // RULE_21
                  next_st.fail = 1'b1;
                end else begin
                  next_st.sub = ARSM_FAULT; // RULE_21
                  next_st.timer = st.cfg.t_fault;
                end
              end else if (timer_done) begin
                next_st.top = ARSM_READY; // RULE_20
                next_st.ok = 1'b1;
              end
            end
            default: next_st.sub = ARSM_FAULT;
          endcase
        end
      end
      default: next_st.top = ARSM_STANDBY;
    endcase
  end

  // State register; reset gives Standby with the shot counter cleared.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '{ARSM_STANDBY, ARSM_FAULT, 32'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
              32'h0, '{CTRL_RST, SHOTS_RST, TIMER_RST, TIMER_RST, TIMER_RST,
                       TIMER_RST, TIMER_RST, TIMER_RST}}; // RULE_23
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from flip-flops.
  assign o_rdata = st.rdata;
  assign o_reclose_cmd = st.reclose;
  assign o_shot_count = st.shot;
  assign o_successful = st.ok;
  assign o_failed = st.fail;
  assign o_state = st.top;

  sequence SEQ_TRIP_IN_FAULT;
    st.top == ARSM_RUN && st.sub == ARSM_FAULT && in.init_trip && !blocked
      && !in.rate_exceeded;
  endsequence

  AST_NO_SHOT_STANDBY: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_03
    $past(st.top) == ARSM_STANDBY |-> !o_reclose_cmd)
    else $error("Reclose issued from standby.");

  AST_CLOSE_TO_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_04
    st.top == ARSM_STANDBY && close_edge && !blocked |=> st.top == ARSM_HOLD)
    else $error("Closing in standby did not enter hold.");

  AST_HOLD_EXIT: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_05
    st.top == ARSM_HOLD && timer_done
      |=> st.top == ($past(in.brk_closed) ? ARSM_READY : ARSM_STANDBY))
    else $error("Hold exit wrong.");

  AST_RUN_FROM_READY: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_07
    st.top == ARSM_RUN && $past(st.top) != ARSM_RUN |-> $past(st.top) == ARSM_READY)
    else $error("Run entered from other than ready.");

  AST_TRIP_TO_WAIT: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_13
    SEQ_TRIP_IN_FAULT |=> st.sub == ARSM_WAIT_OPEN && st.timer == 32'(BRK_SUPV_CYC))
    else $error("Trip did not start breaker supervision.");

  AST_SHOT_WITH_CMD: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_17
    $rose(o_reclose_cmd) |-> o_shot_count == $past(o_shot_count) + 4'h1
      && st.sub == ARSM_RECLOSING)
    else $error("Shot count not advanced with reclose.");

  AST_CONF_TIMER: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_18
    o_reclose_cmd |-> st.timer == st.cfg.t_conf)
    else $error("Confirmation timer not loaded.");

  AST_SUCCESS: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_20
    $rose(o_successful) |-> st.top == ARSM_READY && $past(st.sub) == ARSM_SETTLE)
    else $error("Success flag without settle.");

  AST_FAIL_LOCK: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_21
    $rose(o_failed) |-> st.top == ARSM_LOCKOUT)
    else $error("Failed flag without lockout.");

  AST_BLOCK: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_09
    st.top == ARSM_RUN && blocked |=> st.top == ARSM_BLOCKED)
    else $error("Block ignored during run.");

  AST_READY_TO_STANDBY: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_02
    st.top == ARSM_READY && !in.brk_closed |=> st.top == ARSM_STANDBY)
    else $error("Open breaker did not return to standby.");

  AST_START_GATED: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_01
    st.top == ARSM_READY && !allowed |=> st.top != ARSM_RUN)
    else $error("Run entered while not allowed.");

  AST_START_NEEDS_INIT: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_08
    st.top == ARSM_READY && !init_any |=> st.top != ARSM_RUN)
    else $error("Run entered with no initiation.");

  AST_BLOCK_EXIT: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_09
    st.top == ARSM_BLOCKED && !blocked |=> st.top != ARSM_BLOCKED)
    else $error("Blocked kept after block went away.");

  AST_LOCKOUT_STAYS: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_11
    st.top == ARSM_LOCKOUT && !st.lo_req |=> st.top == ARSM_LOCKOUT)
    else $error("Lockout left without a reset request.");

  AST_NO_ALARM_LOCK: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_12
    st.top == ARSM_READY && in.svc_alarm && in.brk_closed && !blocked && !init_any
      |=> st.top == ARSM_READY)
    else $error("Service alarm disturbed ready.");

  AST_HOLD_TIMER_RUNS: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_22
    st.top == ARSM_HOLD && !timer_done
      |=> st.top == ARSM_HOLD && st.timer == $past(st.timer) - 32'h0000_0001)
    else $error("Hold timer stopped early.");

  // Shot-cycle checks other than AST_RECLOSE_GATED share one guard: Run with no block and no hourly limit, since
  // either of those overrides whatever the current substate would do next.
  sequence SEQ_RUN_CLEAR;
    st.top == ARSM_RUN && !blocked && !in.rate_exceeded;
  endsequence

  AST_FAULT_TIMEOUT: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_10
    SEQ_RUN_CLEAR ##0 (st.sub == ARSM_FAULT && timer_done && !in.init_trip)
      |=> st.top == ARSM_LOCKOUT)
    else $error("Fault timer expiry did not lock out.");

  AST_OPEN_TO_DEAD: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_14
    SEQ_RUN_CLEAR ##0 (st.sub == ARSM_WAIT_OPEN && !in.brk_closed)
      |=> st.sub == ARSM_DEAD && st.timer == $past(st.cfg.t_dead))
    else $error("Open breaker did not start dead time.");

  AST_DEAD_RUNS: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_15
    SEQ_RUN_CLEAR ##0 (st.sub == ARSM_DEAD && !timer_done && !in.brk_closed)
      |=> st.top == ARSM_RUN && st.sub == ARSM_DEAD)
    else $error("Dead time interrupted.");

  AST_RECLOSE_GATED: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_16
    $rose(o_reclose_cmd) |-> !$past(in.brk_closed) && !$past(in.init_pickup)
      && !$past(in.init_trip) && !$past(in.gen_trip)
      && (!$past(st.cfg.ctrl[CTRL_RDY_USED]) || $past(in.brk_ready)))
    else $error("Reclose issued against its conditions.");

  AST_CLOSE_TO_SETTLE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_19
    SEQ_RUN_CLEAR ##0 (st.sub == ARSM_RECLOSING && in.brk_closed)
      |=> st.sub == ARSM_SETTLE && st.timer == $past(st.cfg.t_settle))
    else $error("Closing did not start settle time.");

  AST_SHOTS_USED: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_21
    SEQ_RUN_CLEAR ##0 (st.sub == ARSM_SETTLE && init_any && st.shot >= st.cfg.shots)
      |=> st.top == ARSM_LOCKOUT && o_failed)
    else $error("Exhausted shots did not lock out as failed.");

endmodule

`default_nettype wire

/* File: src/arsm_pkg.sv */
package arsm_pkg;

  // Clock rate and timing figures.
  localparam int CLK_HZ = 10_000_000;
  localparam int BRK_SUPV_MS = 200;
  localparam int BRK_SUPV_CYC = BRK_SUPV_MS * (CLK_HZ / 1000);

  // Register offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SHOTS = 4'h1;
  localparam logic [3:0] REG_T_HOLD = 4'h2;
  localparam logic [3:0] REG_T_FAULT = 4'h3;
  localparam logic [3:0] REG_T_DEAD = 4'h4;
  localparam logic [3:0] REG_T_CONF = 4'h5;
  localparam logic [3:0] REG_T_SETTLE = 4'h6;
  localparam logic [3:0] REG_T_LORST = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;

  // Control register bit positions.
  localparam int CTRL_EN = 0;
  localparam int CTRL_BRK = 1;
  localparam int CTRL_RDY_USED = 2;

  // Reset values.
  localparam logic [2:0] CTRL_RST = 3'h3;
  localparam logic [3:0] SHOTS_RST = 4'h2;
  localparam logic [31:0] TIMER_RST = 32'h0000_03E8;

  // Top-level and shot-cycle states.
  typedef enum logic [2:0] {
    ARSM_STANDBY, ARSM_HOLD, ARSM_READY, ARSM_RUN, ARSM_BLOCKED, ARSM_LOCKOUT
  } arsm_top_e;

  typedef enum logic [2:0] {
    ARSM_FAULT, ARSM_WAIT_OPEN, ARSM_DEAD, ARSM_RECLOSING, ARSM_SETTLE
  } arsm_sub_e;

  // Inputs from the breaker and protection functions.
  typedef struct packed {
    logic brk_closed;
    logic brk_ready;
    logic init_pickup;
    logic init_trip;
    logic gen_trip;
    logic block_fc;
    logic [1:0] ext_block;
    logic lo_reset;
    logic rate_exceeded;
    logic svc_alarm;
  } arsm_in_s;

  // Configuration held in registers.
  typedef struct packed {
    logic [2:0] ctrl;
    logic [3:0] shots;
    logic [31:0] t_hold;
    logic [31:0] t_fault;
    logic [31:0] t_dead;
    logic [31:0] t_conf;
    logic [31:0] t_settle;
    logic [31:0] t_lorst;
  } arsm_cfg_s;

endpackage

/* File: tb/arsm_brk_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Breaker with a slow mechanism: it opens a few cycles after a trip and closes
// a few cycles after a reclose pulse, so only a manual close reaches the block at once.
module arsm_brk_model #(
  parameter int DLY = 3
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_trip,
  input wire logic i_reclose,
  input wire logic i_man_close,
  output logic o_closed
);
  int cnt;
  logic tgt;

  // Mechanism timer; a manual close acts at once, as an operator would.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_closed <= 1'b0;
      cnt <= 0;
      tgt <= 1'b0;
    end else if (i_man_close) begin
      o_closed <= 1'b1;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        o_closed <= tgt;
      end
    end else if (i_trip && o_closed) begin
      cnt <= DLY;
      tgt <= 1'b0;
    end else if (i_reclose && !o_closed) begin
      cnt <= DLY;
      tgt <= 1'b1;
    end
  end
endmodule

`default_nettype wire

/* File: tb/test_autoreclose_state_machine.sv */
`timescale 1ns/1ps
`default_nettype none

module test_autoreclose_state_machine;
  import arsm_pkg::*;
  localparam logic [31:0] M_ALL = 32'h3F77;
  localparam logic [31:0] M_NS = 32'h3F07;
  localparam logic [31:0] M_TOP = 32'h3007;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic trip = 1'b0;
  logic blk_fc = 1'b0;
  logic [1:0] ext_blk = 2'h0;
  logic lo_rst = 1'b0;
  logic rate_ex = 1'b0;
  logic svc = 1'b0;
  logic man_cl = 1'b0;
  logic brk_rdy = 1'b1;
  logic gen_tr = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic rd_seen = 1'b0;
  logic brk, rcl, ok, fl;
  logic [31:0] o_rdata, dead;
  logic [3:0] shot;
  logic [2:0] o_state;
  logic [63:0] q[$];
  logic [63:0] ent;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;

  always #50 i_clk = ~i_clk;

  arsm_top arsm_top_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_brk_closed(brk),
    .i_brk_ready(brk_rdy), .i_init_pickup(trip), .i_init_trip(trip), .i_gen_trip(gen_tr),
    .i_block_fc(blk_fc), .i_external_block_inputs(ext_blk), .i_lo_reset(lo_rst),
    .i_rate_exceeded(rate_ex), .i_svc_alarm(svc), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_reclose_cmd(rcl),
    .o_shot_count(shot), .o_successful(ok), .o_failed(fl), .o_state(o_state));
  arsm_brk_model arsm_brk_model_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_trip(trip),
    .i_reclose(rcl), .i_man_close(man_cl), .o_closed(brk));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    comparisons++;
    if ((got & m) !== (e & m)) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  // Read data stand only in the cycle after the strobe, so compare exactly there.
  always @(posedge i_clk) begin
    cyc++;
    if (rd_seen && q.size() > 0) begin
      ent = q.pop_front();
      chk(o_rdata, ent[31:0], ent[63:32]);
    end
    rd_seen <= i_rd;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    // One idle edge keeps a following call from re-raising the strobe in this step.
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    i_rd <= 1'b1;
    i_addr <= a;
    q.push_back({m, e});
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic stat(input logic f, input logic o, input logic [3:0] s,
                      input logic [2:0] t, input logic [2:0] sub, input logic [31:0] m);
    rd(REG_STATUS, {18'h0, f, o, s, 1'b0, sub, 1'b0, t}, m);
  endtask

  task automatic wait_st(input arsm_top_e s);
    int n;
    n = 0;
    while (o_state !== s && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    chk(n, 0, (n < 3000) ? 32'h0 : 32'hFFFF_FFFF);
  endtask

  task automatic wait_rcl(input logic [3:0] k);
    int n;
    n = 0;
    while (rcl !== 1'b1 && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    chk(n, 0, (n < 3000) ? 32'h0 : 32'hFFFF_FFFF);
    chk({28'h0, shot}, {28'h0, k}, 32'hF);
  endtask

  // Short timers keep each cycle of the sequence to a few dozen clocks.
  task automatic setup();
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    stat(0, 0, 0, ARSM_STANDBY, 0, M_NS);
    wr(REG_T_HOLD, 32'h14);
    wr(REG_T_FAULT, 32'h1E);
    wr(REG_T_DEAD, dead);
    wr(REG_T_CONF, 32'h14);
    wr(REG_T_SETTLE, 32'h0F);
    wr(REG_T_LORST, 32'h08);
  endtask

  task automatic close_to_ready();
    man_cl <= 1'b1;
    @(posedge i_clk);
    man_cl <= 1'b0;
    wait_st(ARSM_HOLD);
  endtask

  task automatic shot_cycle(input logic [3:0] k);
    trip <= 1'b1;
    repeat (6) @(posedge i_clk);
    trip <= 1'b0;
    stat(0, 0, k - 4'h1, ARSM_RUN, ARSM_DEAD, M_ALL);
    wait_rcl(k);
    repeat (6) @(posedge i_clk);
    stat(0, 0, k, ARSM_RUN, ARSM_SETTLE, M_ALL);
  endtask

  initial begin
    dead = $urandom(32'hCE3D);
    dead = 32'hA + ($urandom % 32'h14);
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(REG_CTRL, 32'h3, 32'h7);
    rd(REG_SHOTS, 32'h2, 32'hF);
    rd(REG_T_HOLD, TIMER_RST, 32'hFFFF_FFFF);
    rd(4'hF, 32'h0, 32'hFFFF_FFFF);
    wr(REG_STATUS, 32'hFFFF_FFFF);
    setup();
    rd(REG_T_DEAD, dead, 32'hFFFF_FFFF);
    $display("register test done");
    close_to_ready();
    trip <= 1'b1;
    repeat (6) @(posedge i_clk);
    trip <= 1'b0;
    stat(0, 0, 0, ARSM_HOLD, 0, M_NS);
    wait_st(ARSM_STANDBY);
    close_to_ready();
    repeat (8) @(posedge i_clk);
    stat(0, 0, 0, ARSM_HOLD, 0, M_NS);
    wait_st(ARSM_READY);
    svc <= 1'b1;
    repeat (5) @(posedge i_clk);
    svc <= 1'b0;
    stat(0, 0, 0, ARSM_READY, 0, M_NS);
    $display("manual close test done");
    shot_cycle(4'h1);
    wait_st(ARSM_READY);
    stat(0, 1, 1, ARSM_READY, 0, M_NS);
    chk({31'h0, ok}, 32'h1, 32'h1);
    $display("successful shot test done");
    for (int i = 0; i < 2; i++) begin
      ext_blk <= (i == 0) ? 2'(1 + ($urandom % 3)) : 2'h0;
      blk_fc <= (i == 1);
      wait_st(ARSM_BLOCKED);
      ext_blk <= 2'h0;
      blk_fc <= 1'b0;
      wait_st(ARSM_READY);
    end
    $display("blocking test done");
    trip <= 1'b1;
    rate_ex <= 1'b1;
    wait_st(ARSM_LOCKOUT);
    trip <= 1'b0;
    rate_ex <= 1'b0;
    lo_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    stat(0, 0, 0, ARSM_LOCKOUT, 0, M_TOP);
    wait_st(ARSM_STANDBY);
    lo_rst <= 1'b0;
    $display("lockout test done");
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    setup();
    close_to_ready();
    wait_st(ARSM_READY);
    shot_cycle(4'h1);
    shot_cycle(4'h2);
    trip <= 1'b1;
    wait_st(ARSM_LOCKOUT);
    trip <= 1'b0;
    stat(1, 0, 2, ARSM_LOCKOUT, 0, M_NS);
    chk({31'h0, fl}, 32'h1, 32'h1);
    $display("permanent fault test done");
    // Not-ready breaker, then a general trip, must each stop the shot at dead expiry.
    wr(REG_CTRL, 32'h7);
    for (int i = 0; i < 2; i++) begin
      lo_rst <= 1'b1;
      wait_st(ARSM_STANDBY);
      lo_rst <= 1'b0;
      close_to_ready();
      wait_st(ARSM_READY);
      brk_rdy <= (i == 1);
      gen_tr <= (i == 1);
      trip <= 1'b1;
      repeat (6) @(posedge i_clk);
      trip <= 1'b0;
      wait_st(ARSM_LOCKOUT);
      brk_rdy <= 1'b1;
      gen_tr <= 1'b0;
      stat(0, 0, 0, ARSM_LOCKOUT, ARSM_DEAD, M_ALL);
    end
    $display("reclose condition test done");
    repeat (3) @(posedge i_clk);
    end_of_test();
  end
endmodule

`default_nettype wire
